// ===== inc/fae_params.svh
// Constants for the flash access error checker.
`ifndef FAE_PARAMS_SVH
`define FAE_PARAMS_SVH
`define FAE_LIMIT_32K        16'h7fff
`define FAE_LIMIT_64K        16'hfbff
`define FAE_ADDR_CTRL        32'h0000_0000
`define FAE_ADDR_SRC         32'h0000_0004
`define FAE_ADDR_STAT        32'h0000_0008
`define FAE_ADDR_MASK        32'h0000_000c
`define FAE_ADDR_ERRADR      32'h0000_0010
`define FAE_SRC_FERR_BIT     6
`define FAE_SRC_EXT_BIT      0
`define FAE_SRC_OTHER_BIT    1
`define FAE_CTRL_RESET       8'h00
`define FAE_PULSE_CYCLES     8'h10
`define FAE_NUM_CAUSES       5
`endif

// ===== inc/fae_pkg.sv
// Types shared by the flash access error checker files.
package fae_pkg;
    typedef enum logic [2:0] {
        FAE_K_WRITE  = 3'b000,
        FAE_K_ERASE  = 3'b001,
        FAE_K_READ   = 3'b010,
        FAE_K_FETCH  = 3'b011,
        FAE_K_NONE   = 3'b111
    } fae_kind_e;
    typedef enum logic [1:0] {
        FAE_ST_RUN   = 2'b00,
        FAE_ST_RESET = 2'b01
    } fae_state_e;
endpackage

// ===== inc/fae_chk_if.sv
// Access check request and verdict between the top and the checker.
`timescale 1ns/10ps
interface fae_chk_if;
    import fae_pkg::*;
    logic        valid;
    fae_kind_e   kind;
    logic [15:0] addr;
    logic        big_flash;
    logic        program_store_write_enable;
    logic        restrict_rd;
    logic        restrict_wr;
    logic        vmon_en;
    logic [4:0]  cause;
    modport top (output valid, kind, addr, big_flash, program_store_write_enable, restrict_rd, restrict_wr, vmon_en, input cause);
    modport chk (input valid, kind, addr, big_flash, program_store_write_enable, restrict_rd, restrict_wr, vmon_en, output cause);
endinterface

// ===== rtl/fae_checker.sv
// Combinational legality check of one flash access.
`timescale 1ns/10ps
`include "fae_params.svh"
module fae_checker
    import fae_pkg::*;
(
    fae_chk_if.chk c
);
    logic [15:0] limit;
    logic        is_wr;
    logic        is_rd;
    always_comb begin
        limit = c.big_flash ? `FAE_LIMIT_64K : `FAE_LIMIT_32K;
        is_wr = (c.kind == FAE_K_WRITE) || (c.kind == FAE_K_ERASE);
        is_rd = (c.kind == FAE_K_READ);
        c.cause    = '0;
        if (c.valid) begin
            c.cause[0] = is_wr && c.program_store_write_enable && (c.addr > limit); // RULE_02
            c.cause[1] = is_rd && (c.addr > limit); // RULE_03
            c.cause[2] = (c.kind == FAE_K_FETCH) && (c.addr > limit); // RULE_04
            c.cause[3] = (is_rd && c.restrict_rd) || (is_wr && c.restrict_wr); // RULE_05
            c.cause[4] = is_wr && !c.vmon_en; // RULE_06
        end
    end
endmodule

// ===== rtl/fae_top.sv
// Flash access error reset generator with AHB-Lite register slave.
//
// Function
// [RULE_01] Illegal flash read, write, erase or fetch address raises a system reset.
// [RULE_02] Enabled store write above user code limit raises the error reset.
// [RULE_03] Code space read above user code limit raises the error reset.
// [RULE_04] Fetch from branch target above user code limit raises the error reset.
// [RULE_05] Access forbidden by flash security raises the error reset.
// [RULE_06] Flash write or erase with supply monitor off raises the error reset.
// [RULE_07] Flash error flag, bit 6 of reset source register, set after error reset.
// [RULE_08] Error reset is internal only and never touches the external reset pin.
// [RULE_09] Flash error flag cleared by any reset from another cause; here only by one seen in FAE_ST_RUN with no error in that cycle.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "fae_params.svh"
module fae_top
    import fae_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_acc_valid,
    input  wire fae_kind_e   i_acc_kind,
    input  wire logic [15:0] i_acc_addr,
    input  wire logic        i_big_flash,
    input  wire logic        i_restrict_rd,
    input  wire logic        i_restrict_wr,
    input  wire logic        i_vmon_en,
    input  wire logic        i_ext_rst_seen,
    input  wire logic        i_other_rst_seen,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic             o_acc_block,
    output logic             o_sys_reset,
    output logic             o_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        fae_state_e  st;
        logic [7:0]  cnt;
        logic        program_store_write_enable;
        logic [7:0]  src;
        logic [4:0]  stat;
        logic [4:0]  mask;
        logic [15:0] err_addr;
        logic        ph_wr;
        logic [4:0]  ph_addr;
        logic [31:0] rdata;
    } fae_state_s;

    fae_state_s s_r;
    fae_state_s s_nxt;

    fae_chk_if chk ();

    assign chk.valid       = i_acc_valid && (s_r.st == FAE_ST_RUN);
    assign chk.kind        = i_acc_kind;
    assign chk.addr        = i_acc_addr;
    assign chk.big_flash   = i_big_flash;
    assign chk.program_store_write_enable        = s_r.program_store_write_enable;
    assign chk.restrict_rd = i_restrict_rd;
    assign chk.restrict_wr = i_restrict_wr;
    assign chk.vmon_en     = i_vmon_en;

    fae_checker u_chk (
        .c (chk)
    );

    logic       err;
    logic       take;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        err   = |chk.cause; // RULE_01
        take  = i_hsel && i_hready && i_htrans[1];
        rd_mux = 32'h0000_0000;
        s_nxt.ph_wr = 1'b0;
        if (s_r.ph_wr) begin
            case ({s_r.ph_addr, 2'b00})
                7'(`FAE_ADDR_CTRL): s_nxt.program_store_write_enable = i_hwdata[0];
                7'(`FAE_ADDR_MASK): s_nxt.mask = i_hwdata[4:0];
                default: ;
            endcase
        end
        // Read data is latched at the address phase so it stands through the data phase.
        // It uses the next-state copy so that a read right behind a write sees the new value.
        unique case ({i_haddr[6:2], 2'b00})
            7'(`FAE_ADDR_CTRL):   rd_mux = {31'h0, s_nxt.program_store_write_enable};
            7'(`FAE_ADDR_SRC):    rd_mux = {24'h0, s_r.src};
            7'(`FAE_ADDR_STAT):   rd_mux = {27'h0, s_r.stat};
            7'(`FAE_ADDR_MASK):   rd_mux = {27'h0, s_nxt.mask};
            7'(`FAE_ADDR_ERRADR): rd_mux = {16'h0, s_r.err_addr};
            default:              rd_mux = 32'h0000_0000;
        endcase
        if (take) begin
            s_nxt.ph_wr   = i_hwrite;
            s_nxt.ph_addr = i_haddr[6:2];
            if (!i_hwrite) begin
                s_nxt.rdata = rd_mux;
                if ({i_haddr[6:2], 2'b00} == 7'(`FAE_ADDR_STAT)) begin
                    s_nxt.stat = '0;
                end
            end
        end
        // A cause in the same cycle as the clearing read still sets its bit.
        s_nxt.stat = s_nxt.stat | chk.cause;
        case (s_r.st)
            FAE_ST_RUN: begin
                if (err) begin
                    s_nxt.st       = FAE_ST_RESET;
                    s_nxt.cnt      = `FAE_PULSE_CYCLES;
                    s_nxt.err_addr = i_acc_addr;
                    s_nxt.src      = 8'h00;
                    s_nxt.src[`FAE_SRC_FERR_BIT] = 1'b1; // RULE_07
                    s_nxt.program_store_write_enable     = 1'b0;
                end else if (i_ext_rst_seen || i_other_rst_seen) begin
                    s_nxt.src = 8'h00; // RULE_09
                    s_nxt.src[`FAE_SRC_EXT_BIT]   = i_ext_rst_seen;
                    s_nxt.src[`FAE_SRC_OTHER_BIT] = i_other_rst_seen && !i_ext_rst_seen;
                    s_nxt.program_store_write_enable = 1'b0;
                end
            end
            FAE_ST_RESET: begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                if (s_r.cnt == 8'h01) begin
                    s_nxt.st = FAE_ST_RUN;
                end
            end
            default: s_nxt.st = FAE_ST_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // The reset goes only to internal logic; no pin output exists.
    assign o_sys_reset = (s_r.st == FAE_ST_RESET); // RULE_08
    assign o_acc_block = err; // RULE_01
    assign o_irq       = |(s_r.stat & s_r.mask);
    assign o_hrdata    = s_r.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
endmodule

// ===== tb/fae_top_props.sv
// Assertion checker for the flash access error reset block.
`timescale 1ns/10ps
`include "fae_params.svh"
module fae_top_props
    import fae_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_rstn,
    input wire logic        i_acc_valid,
    input wire fae_kind_e   i_acc_kind,
    input wire logic [15:0] i_acc_addr,
    input wire logic        i_big_flash,
    input wire logic        i_restrict_rd,
    input wire logic        i_vmon_en,
    input wire logic        o_acc_block,
    input wire logic        o_sys_reset
);
    logic [15:0] lim;
    logic        pres;
    assign lim  = i_big_flash ? `FAE_LIMIT_64K : `FAE_LIMIT_32K;
    assign pres = i_acc_valid && !o_sys_reset;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    property p_rd_above; pres && i_acc_kind == FAE_K_READ && i_acc_addr > lim |-> o_acc_block; endproperty
    a_rd_above: assert property (p_rd_above) else $error("read above limit passed");
    property p_fetch_above; pres && i_acc_kind == FAE_K_FETCH && i_acc_addr > lim |-> o_acc_block; endproperty
    a_fetch_above: assert property (p_fetch_above) else $error("fetch above limit passed");
    property p_fetch_ok; pres && i_acc_kind == FAE_K_FETCH && i_acc_addr <= lim |-> !o_acc_block; endproperty
    a_fetch_ok: assert property (p_fetch_ok) else $error("legal fetch blocked");
    property p_sec; pres && i_acc_kind == FAE_K_READ && i_restrict_rd |-> o_acc_block; endproperty
    a_sec: assert property (p_sec) else $error("secured read passed");
    property p_vmon; pres && i_acc_kind inside {FAE_K_WRITE, FAE_K_ERASE} && !i_vmon_en |-> o_acc_block; endproperty
    a_vmon: assert property (p_vmon) else $error("write without monitor passed");
    property p_cause; o_acc_block |=> o_sys_reset; endproperty
    a_cause: assert property (p_cause) else $error("block without reset");
    property p_len; $rose(o_sys_reset) |-> o_sys_reset[*8] ##1 o_sys_reset[*8] ##1 !o_sys_reset; endproperty
    a_len: assert property (p_len) else $error("reset pulse length wrong");
    property p_idle; $rose(o_sys_reset) |-> $past(o_acc_block) && !$past(o_sys_reset); endproperty
    a_idle: assert property (p_idle) else $error("reset without cause");
endmodule
bind fae_top fae_top_props i_fae_top_props (
    .i_core_clk    (i_core_clk),
    .i_rstn        (i_rstn),
    .i_acc_valid   (i_acc_valid),
    .i_acc_kind    (i_acc_kind),
    .i_acc_addr    (i_acc_addr),
    .i_big_flash   (i_big_flash),
    .i_restrict_rd (i_restrict_rd),
    .i_vmon_en     (i_vmon_en),
    .o_acc_block   (o_acc_block),
    .o_sys_reset   (o_sys_reset)
);

// ===== tb/fae_core_model.sv
// Core model that presents one flash access at a time.
`timescale 1ns/10ps
module fae_core_model
    import fae_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_block,
    output logic        o_valid,
    output fae_kind_e   o_kind,
    output logic [15:0] o_addr
);
    initial begin
        o_valid = 1'b0;
        o_kind  = FAE_K_NONE;
        o_addr  = 16'h0000;
    end
    // Holds an access one cycle; the address is inverted after so no stale value remains.
    task automatic issue(input fae_kind_e k, input logic [15:0] a, output logic b);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_kind  <= k;
        o_addr  <= a;
        @(posedge i_clk);
        b = i_block;
        o_valid <= 1'b0;
        o_kind  <= FAE_K_NONE;
        o_addr  <= ~a;
    endtask
endmodule

// ===== tb/test_fae_top.sv
// Self-checking bench for the flash access error reset block.
`timescale 1ns/10ps
`include "fae_params.svh"
module test_fae_top;
    import fae_pkg::*;
    logic        clk, rstn, big, rrd, rwr, vm, oth, ext, sel, wr, blk, sysr, irq, rdy, resp, valid, e, s, p;
    logic [4:0]  cz;
    fae_kind_e   kind, k;
    logic [15:0] addr, a, lim;
    logic [1:0]  tr;
    logic [31:0] ad, wd, rd, r;
    int          n_errors, checks;
    fae_top i_fae_top (.i_core_clk(clk), .i_rstn(rstn), .i_acc_valid(valid), .i_acc_kind(kind),
        .i_acc_addr(addr), .i_big_flash(big), .i_restrict_rd(rrd), .i_restrict_wr(rwr), .i_vmon_en(vm),
        .i_ext_rst_seen(ext), .i_other_rst_seen(oth), .i_hsel(sel), .i_haddr(ad), .i_htrans(tr),
        .i_hwrite(wr), .i_hsize(3'h2), .i_hwdata(wd), .i_hready(rdy), .o_hrdata(rd), .o_hreadyout(rdy),
        .o_hresp(resp), .o_acc_block(blk), .o_sys_reset(sysr), .o_irq(irq));
    fae_core_model i_fae_core_model (.i_clk(clk), .i_block(blk), .o_valid(valid), .o_kind(kind), .o_addr(addr));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] adr, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        sel <= 1'b1;
        tr  <= 2'h2;
        ad  <= adr;
        wr  <= w;
        do @(posedge clk); while (!rdy);
        sel <= 1'b0;
        tr  <= 2'h0;
        wd  <= d;
        do @(posedge clk); while (!rdy);
        q = rd;
    endtask
    // Expected status causes: monitor off, security, fetch above, read above, write above.
    function automatic logic [4:0] causes(fae_kind_e kk, logic [15:0] aa, logic [15:0] l, logic pw, rr, rw, v);
        logic wk;
        wk = (kk == FAE_K_WRITE) || (kk == FAE_K_ERASE);
        return {wk && !v, (kk == FAE_K_READ && rr) || (wk && rw), kk == FAE_K_FETCH && aa > l,
                kk == FAE_K_READ && aa > l, wk && pw && aa > l};
    endfunction
    initial begin
        #40000;
        n_errors++;
        conclude;
    end
    initial begin
        {rstn, big, rrd, rwr, vm, oth, ext, sel, wr, tr, ad, wd, n_errors, checks} = '0;
        void'($urandom(44));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, 32'h0000_0020, 32'h0, r);
        chk(r, 32'h0);
        for (int i = 0; i < 60; i++) begin
            p = 1'($urandom);
            bus(1'b1, `FAE_ADDR_CTRL, {31'h0, p}, r);
            bus(1'b1, `FAE_ADDR_MASK, (i < 30) ? 32'h1f : 32'h0, r);
            {big, rrd, rwr, vm} <= 4'($urandom);
            k = fae_kind_e'(3'($urandom % 4));
            @(posedge clk);
            lim = big ? `FAE_LIMIT_64K : `FAE_LIMIT_32K;
            a = (i % 4 == 0) ? lim : (i % 4 == 1) ? lim + 16'h1 : 16'($urandom);
            cz = causes(k, a, lim, p, rrd, rwr, vm);
            e = |cz;
            i_fae_core_model.issue(k, a, s);
            chk(s, e);
            @(negedge clk);
            chk(sysr, e);
            if (e) begin
                repeat (17) @(posedge clk);
                bus(1'b0, `FAE_ADDR_SRC, 32'h0, r);
                chk(r, 32'h1 << `FAE_SRC_FERR_BIT);
                chk(resp, 1'b0);
                chk(irq, i < 30);
                bus(1'b0, `FAE_ADDR_ERRADR, 32'h0, r);
                chk(r, {16'h0, a});
                bus(1'b0, `FAE_ADDR_STAT, 32'h0, r);
                chk(r, {27'h0, cz});
                @(posedge clk);
                chk(irq, 1'b0);
                ext <= i[0];
                oth <= 1'b1;
                @(posedge clk);
                {ext, oth} <= 2'b00;
                bus(1'b0, `FAE_ADDR_SRC, 32'h0, r);
                chk(r, 32'h1 << (i[0] ? `FAE_SRC_EXT_BIT : `FAE_SRC_OTHER_BIT));
            end
        end
        conclude;
    end
endmodule
